// ===== hw/sbi_pkg.sv
// sbi_pkg: constants for the sensor bus start-up sequencer and command decoder
// assumes a 100 MHz block clock; no other package is referenced
package sbi_pkg;
   // clock rate and start-up delays
   localparam int unsigned CLK_HZ           = 100_000_000;
   localparam int unsigned BUS_INIT_US      = 1000;  // bus-ready delay, plain default
   localparam int unsigned DSP_INIT_US      = 5000;  // signal-processing ready, default
   localparam int unsigned BUS_INIT_CYC     = BUS_INIT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned DSP_INIT_CYC     = DSP_INIT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned MIRROR_WORDS     = 16;    // fuse words copied to mirror
   // command codes
   localparam logic [3:0] CMD_INIT   = 4'h0;
   localparam logic [3:0] CMD_STATUS = 4'h1;
   localparam logic [3:0] CMD_ACCEL  = 4'h2;
   localparam logic [3:0] CMD_ID     = 4'h4;
   localparam logic [3:0] CMD_CLEAR  = 4'h7;
   localparam logic [3:0] CMD_NVM    = 4'h9;
   localparam logic [3:0] CMD_FMT    = 4'hA;
   localparam logic [3:0] CMD_REGRD  = 4'hB;
   localparam logic [3:0] CMD_ST_OFF = 4'hC;
   localparam logic [3:0] CMD_ST_ON  = 4'hD;
   // data byte field positions
   localparam int unsigned PGM_EN_BIT  = 7;
   localparam int unsigned BUS_SW_BIT  = 6;
   localparam int unsigned BANK_MSB    = 5;
   localparam int unsigned BANK_LSB    = 4;
   localparam int unsigned NIB_HI_MSB  = 7;
   localparam int unsigned NIB_HI_LSB  = 4;
   localparam int unsigned NIB_LO_MSB  = 3;
   localparam int unsigned NIB_LO_LSB  = 0;
   localparam int unsigned FMT_RW_BIT  = 7;
   localparam int unsigned FMT_FA_MSB  = 6;
   localparam int unsigned FMT_FA_LSB  = 4;
   // dispatch kinds handed to the response side
   typedef enum logic [3:0] {
      SBI_OP_NONE, SBI_OP_INIT, SBI_OP_STATUS, SBI_OP_ACCEL, SBI_OP_ID,
      SBI_OP_CLEAR, SBI_OP_NVM, SBI_OP_FMT, SBI_OP_REGRD, SBI_OP_ST_OFF,
      SBI_OP_ST_ON
   } sbi_op_type;
endpackage : sbi_pkg

// ===== hw/sbi_cmd_dec.sv
// sbi_cmd_dec: pure decode of a command code and message format
// assumes the frame flags are stable while msg_valid_i is high
`timescale 1ns/10ps
`default_nettype none
module sbi_cmd_dec (
   input  wire logic [3:0]        code_i,
   input  wire logic              long_i,
   input  wire logic              enhanced_i,
   output sbi_pkg::sbi_op_type    op_o
);
   // format gate per code; anything unlisted decodes to no operation
   always_comb begin
      op_o = sbi_pkg::SBI_OP_NONE;
      case (code_i)
         sbi_pkg::CMD_INIT:   if (long_i && !enhanced_i) op_o = sbi_pkg::SBI_OP_INIT;
         sbi_pkg::CMD_STATUS: op_o = sbi_pkg::SBI_OP_STATUS;
         sbi_pkg::CMD_ACCEL:  op_o = sbi_pkg::SBI_OP_ACCEL;
         sbi_pkg::CMD_ID:     op_o = sbi_pkg::SBI_OP_ID;
         sbi_pkg::CMD_CLEAR:  op_o = sbi_pkg::SBI_OP_CLEAR;
         sbi_pkg::CMD_NVM:    if (long_i) op_o = sbi_pkg::SBI_OP_NVM;
         sbi_pkg::CMD_FMT:    if (long_i) op_o = sbi_pkg::SBI_OP_FMT;
         sbi_pkg::CMD_REGRD:  if (long_i) op_o = sbi_pkg::SBI_OP_REGRD;
         sbi_pkg::CMD_ST_OFF: op_o = sbi_pkg::SBI_OP_ST_OFF;
         sbi_pkg::CMD_ST_ON:  op_o = sbi_pkg::SBI_OP_ST_ON;
         default:             op_o = sbi_pkg::SBI_OP_NONE;
      endcase
   end
endmodule : sbi_cmd_dec
`default_nettype wire

// ===== hw/sbi_top.sv
// sbi_top: start-up sequencer and command decoder of the sensor bus slave
// assumes the link layer delivers one checked message per msg_valid_i pulse
// Overview of operation
// - start-up runs after power-up, under-voltage reset, or a Clear command.
// - first copy fuses to mirror; no answers; start-up flag 1, self-test 0.
// - after bus-ready delay, accept bus messages; start-up flag still set.
// - before signal path ready, short accel read gives zero, long is invalid.
// - after signal-path delay, data valid, start-up flag 0, normal answers.
// - on Clear restart, start-up flag reads 1 at once; silent until bus-ready delay ends.
// - commands in an unlisted format are silently ignored.
// - CRC failure or reserved or unimplemented code gives no answer.
// - answer goes in the next transfer, at most one answer per command; Clear gets none.
// - code 0 initialization, standard long only; enable, switch, bank, address.
// - codes 1, 2, 4 accepted in all four formats, no data.
// - code 7 Clear accepted in all formats, restarts start-up.
// - code 9 nvm access, long only; write address high, data low nibble.
// - code A format control, long only; r/w, field address, field data.
// - code B register read, long only; upper nibble zero, address low.
// - code C stops self-test, code D starts it, all formats.
// - codes 3, 5, 6, 8, E, F unimplemented; no answer.
// - before a valid initialization, no other command is recognized.
// - once initialized, further initialization commands are ignored.
`timescale 1ns/10ps
`default_nettype none
module sbi_top #(
   parameter int unsigned BUS_INIT_CYCLES = sbi_pkg::BUS_INIT_CYC,
   parameter int unsigned DSP_INIT_CYCLES = sbi_pkg::DSP_INIT_CYC,
   parameter int unsigned MIRROR_WORDS    = sbi_pkg::MIRROR_WORDS
) (
   input  wire logic              ref_clk_i,
   input  wire logic              srst_i,
   input  wire logic              uv_reset_i,
   // fuse array read port
   output logic [3:0]             fuse_addr_o,
   output logic                   fuse_rd_o,
   input  wire logic [7:0]        fuse_data_i,
   // received message from link layer
   input  wire logic              msg_valid_i,
   input  wire logic              msg_crc_ok_i,
   input  wire logic              msg_long_i,
   input  wire logic              msg_enhanced_i,
   input  wire logic [3:0]        msg_cmd_i,
   input  wire logic [7:0]        msg_data_i,
   input  wire logic              xfer_start_i,
   // status flags and mirror write port
   output logic                   startup_flag_o,
   output logic                   selftest_active_flag_o,
   output logic                   bus_ready_o,
   output logic                   accel_valid_o,
   output logic                   initialized_o,
   output logic                   mirror_we_o,
   output logic [3:0]             mirror_addr_o,
   output logic [7:0]             mirror_data_o,
   // decoded command and fields, held until replaced; strobe high for one cycle
   output logic                   cmd_stb_o,
   output logic [3:0]             cmd_op_o,
   output logic                   otp_program_enable_o,
   output logic                   bus_switch_close_o,
   output logic [1:0]             bank_select_o,
   output logic [3:0]             assigned_address_o,
   output logic [3:0]             nvm_write_address_o,
   output logic [3:0]             nvm_write_data_o,
   output logic                   format_write_o,
   output logic [2:0]             format_field_address_o,
   output logic [3:0]             format_field_data_o,
   output logic [3:0]             register_read_address_o,
   // answer request for the following transfer
   output logic                   resp_req_o,
   output logic [3:0]             resp_op_o,
   output logic                   resp_accel_zero_o
);
   initial begin
      if (BUS_INIT_CYCLES < 1 || DSP_INIT_CYCLES <= BUS_INIT_CYCLES)
         $error("sbi_top: delays must satisfy 1 <= bus < dsp");
      if (MIRROR_WORDS < 1 || MIRROR_WORDS > 16)
         $error("sbi_top: mirror words must be 1..16");
   end

   typedef enum logic [1:0] {
      SBI_ST_LOAD, SBI_ST_WAIT_BUS, SBI_ST_WAIT_DSP, SBI_ST_RUN
   } sbi_state_type;

   sbi_state_type       state_r;
   logic [31:0]         tick_r;
   logic [3:0]          fuse_idx_r;
   logic                fuse_pend_r;
   logic                startup_r;
   logic                selftest_r;
   logic                inited_r;
   logic                restart;
   logic                accepted;
   logic                pend_r;
   logic [3:0]          pend_op_r;
   logic                pend_zero_r;
   sbi_pkg::sbi_op_type dec_op;
   sbi_pkg::sbi_op_type op;

   // final count of fuse words as an index
   function automatic logic [3:0] last_idx(input int unsigned n);
      last_idx = 4'(n - 1);
   endfunction : last_idx

   // code and format decode
   sbi_cmd_dec u_dec (
      .code_i     (msg_cmd_i),
      .long_i     (msg_long_i),
      .enhanced_i (msg_enhanced_i),
      .op_o       (dec_op)
   );

   // gate decode by checks and start-up state; bad CRC is simply dropped
   always_comb begin
      op = sbi_pkg::SBI_OP_NONE;
      if (msg_valid_i && msg_crc_ok_i && bus_ready_o) begin
         if (!inited_r) begin
            if (dec_op == sbi_pkg::SBI_OP_INIT)
               op = dec_op;
         end else if (dec_op != sbi_pkg::SBI_OP_INIT) begin
            op = dec_op;
         end
      end
   end

   assign accepted = (op != sbi_pkg::SBI_OP_NONE);
   // clear restarts next edge; power-up and under-voltage come via resets
   assign restart  = uv_reset_i || (op == sbi_pkg::SBI_OP_CLEAR);

   // start-up sequencer
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || restart) begin
         state_r <= SBI_ST_LOAD;
      end else begin
         case (state_r)
            SBI_ST_LOAD:
               if (fuse_pend_r && fuse_idx_r == last_idx(MIRROR_WORDS))
                  state_r <= SBI_ST_WAIT_BUS;
            SBI_ST_WAIT_BUS:
               if (tick_r >= BUS_INIT_CYCLES - 1)
                  state_r <= SBI_ST_WAIT_DSP;
            SBI_ST_WAIT_DSP:
               if (tick_r >= DSP_INIT_CYCLES - 1)
                  state_r <= SBI_ST_RUN;
            SBI_ST_RUN:
               state_r <= SBI_ST_RUN;
            default:
               state_r <= SBI_ST_LOAD;
         endcase
      end
   end

   // time since start of initialization; holds its value once running
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || restart)
         tick_r <= 32'h0000_0000;
      else if (state_r != SBI_ST_RUN)
         tick_r <= tick_r + 32'h0000_0001;
   end

   // fuse walk: one read strobe per word, data arrives a cycle later
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || restart) begin
         fuse_idx_r  <= 4'h0;
         fuse_pend_r <= 1'b0;
      end else if (state_r == SBI_ST_LOAD) begin
         fuse_pend_r <= 1'b1;
         if (fuse_pend_r)
            fuse_idx_r <= fuse_idx_r + 4'h1;
      end else begin
         fuse_pend_r <= 1'b0;
      end
   end

   always_comb begin
      fuse_rd_o   = (state_r == SBI_ST_LOAD) && !srst_i;
      fuse_addr_o = fuse_pend_r ? fuse_idx_r + 4'h1 : fuse_idx_r;
   end

   // mirror write port, registered
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         mirror_we_o   <= 1'b0;
         mirror_addr_o <= 4'h0;
         mirror_data_o <= 8'h00;
      end else begin
         mirror_we_o   <= fuse_pend_r && state_r == SBI_ST_LOAD;
         mirror_addr_o <= fuse_idx_r;
         mirror_data_o <= fuse_data_i;
      end
   end

   // start-up flag set at once on any restart, cleared when signal path ready
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || restart)
         startup_r <= 1'b1;
      else if (state_r == SBI_ST_WAIT_DSP && tick_r >= DSP_INIT_CYCLES - 1)
         startup_r <= 1'b0;
   end

   // self-test flag forced off during start-up, else driven by C/D codes
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || restart || state_r != SBI_ST_RUN)
         selftest_r <= 1'b0;
      else if (op == sbi_pkg::SBI_OP_ST_ON)
         selftest_r <= 1'b1;
      else if (op == sbi_pkg::SBI_OP_ST_OFF)
         selftest_r <= 1'b0;
   end

   // initialized after the first accepted init; cleared by any restart
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || restart)
         inited_r <= 1'b0;
      else if (op == sbi_pkg::SBI_OP_INIT)
         inited_r <= 1'b1;
   end

   // field capture per command layout
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         otp_program_enable_o    <= 1'b0;
         bus_switch_close_o      <= 1'b0;
         bank_select_o           <= 2'h0;
         assigned_address_o      <= 4'h0;
         nvm_write_address_o     <= 4'h0;
         nvm_write_data_o        <= 4'h0;
         format_write_o          <= 1'b0;
         format_field_address_o  <= 3'h0;
         format_field_data_o     <= 4'h0;
         register_read_address_o <= 4'h0;
      end else begin
         case (op)
            sbi_pkg::SBI_OP_INIT: begin
               otp_program_enable_o <= msg_data_i[sbi_pkg::PGM_EN_BIT];
               bus_switch_close_o   <= msg_data_i[sbi_pkg::BUS_SW_BIT];
               bank_select_o        <=
                  msg_data_i[sbi_pkg::BANK_MSB:sbi_pkg::BANK_LSB];
               assigned_address_o   <=
                  msg_data_i[sbi_pkg::NIB_LO_MSB:sbi_pkg::NIB_LO_LSB];
            end
            sbi_pkg::SBI_OP_NVM: begin
               nvm_write_address_o <=
                  msg_data_i[sbi_pkg::NIB_HI_MSB:sbi_pkg::NIB_HI_LSB];
               nvm_write_data_o    <=
                  msg_data_i[sbi_pkg::NIB_LO_MSB:sbi_pkg::NIB_LO_LSB];
            end
            sbi_pkg::SBI_OP_FMT: begin
               format_write_o         <= msg_data_i[sbi_pkg::FMT_RW_BIT];
               format_field_address_o <=
                  msg_data_i[sbi_pkg::FMT_FA_MSB:sbi_pkg::FMT_FA_LSB];
               format_field_data_o    <=
                  msg_data_i[sbi_pkg::NIB_LO_MSB:sbi_pkg::NIB_LO_LSB];
            end
            sbi_pkg::SBI_OP_REGRD:
               register_read_address_o <=
                  msg_data_i[sbi_pkg::NIB_LO_MSB:sbi_pkg::NIB_LO_LSB];
            default: ;
         endcase
      end
   end

   // command strobe and op, one cycle after the message
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cmd_stb_o <= 1'b0;
         cmd_op_o  <= 4'h0;
      end else begin
         cmd_stb_o <= accepted;
         if (accepted)
            cmd_op_o <= op;
      end
   end

   // one pending answer, released at the next transfer start only;
   // clear gives no answer since the logic restarts
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || restart) begin
         pend_r      <= 1'b0;
         pend_op_r   <= 4'h0;
         pend_zero_r <= 1'b0;
      end else if (accepted) begin
         pend_r      <= 1'b1;
         pend_op_r   <= op;
         pend_zero_r <= (op == sbi_pkg::SBI_OP_ACCEL) && !msg_long_i
                        && state_r != SBI_ST_RUN;
      end else if (xfer_start_i) begin
         pend_r <= 1'b0;
      end
   end

   // answer request pulses once at the following transfer
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         resp_req_o        <= 1'b0;
         resp_op_o         <= 4'h0;
         resp_accel_zero_o <= 1'b0;
      end else begin
         resp_req_o <= pend_r && xfer_start_i && !accepted;
         if (pend_r && xfer_start_i) begin
            resp_op_o         <= pend_op_r;
            resp_accel_zero_o <= pend_zero_r;
         end
      end
   end

   // status outputs from flops
   always_comb begin
      startup_flag_o         = startup_r;
      selftest_active_flag_o = selftest_r;
      bus_ready_o   = state_r == SBI_ST_WAIT_DSP || state_r == SBI_ST_RUN;
      accel_valid_o = state_r == SBI_ST_RUN;
      initialized_o = inited_r;
   end
endmodule : sbi_top
`default_nettype wire

// ===== dv/sbi_top_properties.sv
// sbi_top_properties: refusal and start-up checks on the sequencer ports
// assumes it is bound to sbi_top and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module sbi_top_properties #(
   parameter int unsigned BUS_INIT_CYCLES = 20,
   parameter int unsigned DSP_INIT_CYCLES = 40,
   parameter int unsigned MIRROR_WORDS    = 4
) (
   input wire logic       ref_clk_i,
   input wire logic       srst_i,
   input wire logic       uv_reset_i,
   input wire logic       fuse_rd_o,
   input wire logic       msg_valid_i,
   input wire logic       msg_crc_ok_i,
   input wire logic       msg_long_i,
   input wire logic       msg_enhanced_i,
   input wire logic [3:0] msg_cmd_i,
   input wire logic       xfer_start_i,
   input wire logic       startup_flag_o,
   input wire logic       selftest_active_flag_o,
   input wire logic       bus_ready_o,
   input wire logic       accel_valid_o,
   input wire logic       initialized_o,
   input wire logic       cmd_stb_o,
   input wire logic       resp_req_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   // restart state: flag raised, message side closed
   sequence s_restarted;
      startup_flag_o && !bus_ready_o;
   endsequence
   // a message that must leave the decoder silent
   property p_silent(cond);
      msg_valid_i && cond |=> !cmd_stb_o;
   endproperty
   bad_crc_a: assert property (p_silent(!msg_crc_ok_i))
      else $error("strobe after bad crc");
   unimpl_code_a: assert property (p_silent(msg_cmd_i inside
      {4'h3, 4'h5, 4'h6, 4'h8, 4'hE, 4'hF})) else $error("unimplemented code");
   init_format_a: assert property (p_silent(msg_cmd_i == 4'h0 &&
      (!msg_long_i || msg_enhanced_i))) else $error("init in wrong format");
   long_only_a: assert property (p_silent(!msg_long_i &&
      msg_cmd_i inside {4'h9, 4'hA, 4'hB})) else $error("short long-only");
   pre_init_a: assert property (p_silent(!initialized_o &&
      msg_cmd_i != 4'h0)) else $error("command before init");
   re_init_a: assert property (p_silent(initialized_o &&
      msg_cmd_i == 4'h0)) else $error("second init taken");
   not_ready_a: assert property (p_silent(!bus_ready_o))
      else $error("message taken before ready");
   stb_cause_a: assert property (cmd_stb_o |->
      $past(msg_valid_i && msg_crc_ok_i)) else $error("strobe without msg");
   one_answer_a: assert property (resp_req_o |->
      $past(xfer_start_i) ##1 !resp_req_o) else $error("answer misplaced");
   flag_pair_a: assert property (startup_flag_o != accel_valid_o)
      else $error("start-up flag against data valid");
   selftest_off_a: assert property (!accel_valid_o |->
      !selftest_active_flag_o) else $error("self-test during start-up");
   fuse_load_a: assert property (fuse_rd_o |-> s_restarted)
      else $error("fuse load with bus open");
   clear_restart_a: assert property (msg_valid_i && msg_crc_ok_i &&
      bus_ready_o && initialized_o && msg_cmd_i == 4'h7 |=> s_restarted)
      else $error("clear did not restart");
   uv_restart_a: assert property (uv_reset_i |=> s_restarted)
      else $error("under-voltage did not restart");
endmodule : sbi_top_properties
`default_nettype wire

// ===== dv/sbi_master_model.sv
// sbi_master_model: bus master sending one checked message per frame
// assumes the caller waits on send; lines scramble once released
`timescale 1ns/10ps
`default_nettype none
module sbi_master_model #(
   parameter int unsigned GAP = 6
) (
   input  wire logic       ref_clk_i,
   output logic            msg_valid_o,
   output logic            msg_crc_ok_o,
   output logic            msg_long_o,
   output logic            msg_enhanced_o,
   output logic [3:0]      msg_cmd_o,
   output logic [7:0]      msg_data_o,
   output logic            xfer_start_o
);
   initial begin
      {msg_valid_o, msg_crc_ok_o, msg_long_o, msg_enhanced_o} = 4'h0;
      {msg_cmd_o, msg_data_o, xfer_start_o} = 13'h0;
   end
   // message, then the following transfer, then the frame gap
   task automatic send(input logic [3:0] c, input logic [7:0] d,
                       input logic l, input logic e, input logic k);
      @(negedge ref_clk_i);
      {msg_valid_o, msg_crc_ok_o, msg_long_o, msg_enhanced_o} = {1'b1, k, l, e};
      {msg_cmd_o, msg_data_o} = {c, d};
      @(negedge ref_clk_i);
      msg_valid_o = 1'b0;
      // released lines flip so stale values cannot pass for fields
      {msg_crc_ok_o, msg_long_o, msg_enhanced_o} = ~{k, l, e};
      {msg_cmd_o, msg_data_o} = ~{c, d};
      repeat (2) @(negedge ref_clk_i);
      xfer_start_o = 1'b1;
      @(negedge ref_clk_i);
      xfer_start_o = 1'b0;
      repeat (GAP) @(negedge ref_clk_i);
   endtask : send
endmodule : sbi_master_model
`default_nettype wire

// ===== dv/testbench.sv
// testbench: start-up, refusal and decode checks of sbi_top
// assumes sbi_pkg, sbi_top and the master model are compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
   // decoded op for each code, 0 where the code is unimplemented
   localparam logic [3:0] OPS [16] = '{4'h1, 4'h2, 4'h3, 4'h0, 4'h4, 4'h0,
      4'h0, 4'h5, 4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'h0, 4'h0};
   logic ref_clk_i, srst_i, uv_reset_i, fuse_rd_o, msg_valid_i, msg_crc_ok_i;
   logic msg_long_i, msg_enhanced_i, xfer_start_i, startup_flag_o;
   logic selftest_active_flag_o, bus_ready_o, accel_valid_o, initialized_o;
   logic mirror_we_o, cmd_stb_o, otp_program_enable_o, bus_switch_close_o;
   logic format_write_o, resp_req_o, resp_accel_zero_o;
   logic [1:0] bank_select_o;
   logic [2:0] format_field_address_o;
   logic [3:0] fuse_addr_o, msg_cmd_i, mirror_addr_o, cmd_op_o, resp_op_o;
   logic [3:0] assigned_address_o, nvm_write_address_o, nvm_write_data_o;
   logic [3:0] format_field_data_o, register_read_address_o;
   logic [7:0] fuse_data_i, msg_data_i, mirror_data_o;
   logic [11:0] stb_q[$];
   logic [4:0] rsp_q[$];
   logic [11:0] es;
   logic [4:0] er;
   int num_errors, checks_done, seed;
   wire logic [7:0] f_init = {otp_program_enable_o, bus_switch_close_o,
                              bank_select_o, assigned_address_o};
   wire logic [7:0] f_fmt = {format_write_o, format_field_address_o,
                             format_field_data_o};

   sbi_top #(.BUS_INIT_CYCLES(20), .DSP_INIT_CYCLES(400), .MIRROR_WORDS(4))
   dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .uv_reset_i(uv_reset_i),
      .fuse_addr_o(fuse_addr_o), .fuse_rd_o(fuse_rd_o),
      .fuse_data_i(fuse_data_i), .msg_valid_i(msg_valid_i),
      .msg_crc_ok_i(msg_crc_ok_i), .msg_long_i(msg_long_i),
      .msg_enhanced_i(msg_enhanced_i), .msg_cmd_i(msg_cmd_i),
      .msg_data_i(msg_data_i), .xfer_start_i(xfer_start_i),
      .startup_flag_o(startup_flag_o), .bus_ready_o(bus_ready_o),
      .selftest_active_flag_o(selftest_active_flag_o),
      .accel_valid_o(accel_valid_o), .initialized_o(initialized_o),
      .mirror_we_o(mirror_we_o), .mirror_addr_o(mirror_addr_o),
      .mirror_data_o(mirror_data_o), .cmd_stb_o(cmd_stb_o),
      .cmd_op_o(cmd_op_o), .otp_program_enable_o(otp_program_enable_o),
      .bus_switch_close_o(bus_switch_close_o), .bank_select_o(bank_select_o),
      .assigned_address_o(assigned_address_o),
      .nvm_write_address_o(nvm_write_address_o),
      .nvm_write_data_o(nvm_write_data_o), .format_write_o(format_write_o),
      .format_field_address_o(format_field_address_o),
      .format_field_data_o(format_field_data_o),
      .register_read_address_o(register_read_address_o),
      .resp_req_o(resp_req_o), .resp_op_o(resp_op_o),
      .resp_accel_zero_o(resp_accel_zero_o));

   sbi_master_model mst (.ref_clk_i(ref_clk_i), .msg_valid_o(msg_valid_i),
      .msg_crc_ok_o(msg_crc_ok_i), .msg_long_o(msg_long_i),
      .msg_enhanced_o(msg_enhanced_i), .msg_cmd_o(msg_cmd_i),
      .msg_data_o(msg_data_i), .xfer_start_o(xfer_start_i));

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // fuse array answers a cycle after the address
   always @(posedge ref_clk_i) fuse_data_i <= {4'h5, fuse_addr_o};

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict

   // note what the decoder must do, then let the master send it
   task automatic cmd(input logic [3:0] c, input logic [7:0] d,
                      input logic l, input logic e, input logic k);
      logic ok;
      ok = k && bus_ready_o && OPS[c] != 4'h0 && initialized_o == (c != 4'h0)
           && (c == 4'h0 ? l && !e : c inside {4'h9, 4'hA, 4'hB} ? l : 1'b1);
      if (ok && c != 4'h7) begin
         stb_q.push_back({OPS[c], d});
         rsp_q.push_back({!l && !accel_valid_o, OPS[c]});
      end
      mst.send(c, d, l, e, k);
   endtask : cmd

   // the Clear strobe, if any, is ignored: the device restarts instead
   always @(posedge ref_clk_i) begin
      if (mirror_we_o === 1'b1)
         check("mirror", {4'h5, mirror_addr_o}, mirror_data_o);
      if (cmd_stb_o === 1'b1 && cmd_op_o !== 4'h5) begin
         es = stb_q.size() ? stb_q.pop_front() : 12'hFFF;
         check("cmd_op", {4'h0, es[11:8]}, {4'h0, cmd_op_o});
         case (es[11:8])
            4'h1: check("init", es[7:0], f_init);
            4'h6: check("nvm", es[7:0], {nvm_write_address_o, nvm_write_data_o});
            4'h7: check("fmt", es[7:0], f_fmt);
            4'h8: check("regrd", es[7:0], {4'h0, register_read_address_o});
            default: ;
         endcase
      end
      if (resp_req_o === 1'b1) begin
         er = rsp_q.size() ? rsp_q.pop_front() : 5'h1F;
         check("resp_op", {4'h0, er[3:0]}, {4'h0, resp_op_o});
         if (er[3:0] == 4'h3)
            check("zero", {7'h0, er[4]}, {7'h0, resp_accel_zero_o});
      end
   end

   initial begin
      repeat (8000) @(posedge ref_clk_i);
      num_errors++;
      give_verdict();
   end

   initial begin
      // fuse data has one driver: the fuse answer process above
      {srst_i, uv_reset_i, num_errors, checks_done} = {2'b10, 64'h0};
      seed = 77;
      repeat (20) @(negedge ref_clk_i);
      srst_i = 1'b0;
      cmd(4'h0, 8'h31, 1'b1, 1'b0, 1'b1);
      check("startup", 8'h01, {7'h0, startup_flag_o});
      for (int i = 0; i < 200 && bus_ready_o !== 1'b1; i++) @(negedge ref_clk_i);
      cmd(4'h1, 8'h00, 1'b1, 1'b0, 1'b1);
      cmd(4'h0, 8'hB3, 1'b1, 1'b1, 1'b1);
      cmd(4'h0, 8'hB3, 1'b0, 1'b0, 1'b1);
      cmd(4'h0, 8'hB3, 1'b1, 1'b0, 1'b0);
      cmd(4'h0, 8'($random(seed)), 1'b1, 1'b0, 1'b1);
      cmd(4'h0, 8'h52, 1'b1, 1'b0, 1'b1);
      cmd(4'h2, 8'h00, 1'b0, 1'b0, 1'b1);
      cmd(4'h2, 8'h00, 1'b1, 1'b1, 1'b1);
      $display("test bring-up done");
      for (int i = 0; i < 600 && accel_valid_o !== 1'b1; i++) @(negedge ref_clk_i);
      check("run_flags", 8'h01, {6'h0, startup_flag_o, accel_valid_o});
      for (int c = 0; c < 16; c++)
         for (int f = 0; f < 4; f++)
            if (c != 7) cmd(4'(c), 8'((c == 11) ? 8'h0F & 8'($random(seed))
               : 8'($random(seed))), f[1], f[0], 1'b1);
      check("selftest", 8'h01, {7'h0, selftest_active_flag_o});
      cmd(4'hC, 8'h00, 1'b0, 1'b1, 1'b1);
      check("selftest", 8'h00, {7'h0, selftest_active_flag_o});
      $display("test decode done");
      cmd(4'h7, 8'h00, 1'b0, 1'b1, 1'b1);
      check("cleared", 8'h02, {6'h0, startup_flag_o, bus_ready_o});
      for (int i = 0; i < 200 && bus_ready_o !== 1'b1; i++) @(negedge ref_clk_i);
      cmd(4'h1, 8'h00, 1'b1, 1'b0, 1'b1);
      cmd(4'h0, 8'h7A, 1'b1, 1'b0, 1'b1);
      uv_reset_i = 1'b1;
      @(negedge ref_clk_i);
      uv_reset_i = 1'b0;
      check("uv", 8'h02, {6'h0, startup_flag_o, bus_ready_o});
      repeat (20) @(negedge ref_clk_i);
      check("pending", 8'h00, 8'(stb_q.size() + rsp_q.size()));
      $display("test restart done");
      give_verdict();
   end
endmodule : testbench

bind sbi_top sbi_top_properties #(.BUS_INIT_CYCLES(BUS_INIT_CYCLES),
   .DSP_INIT_CYCLES(DSP_INIT_CYCLES), .MIRROR_WORDS(MIRROR_WORDS)) chk (
   .ref_clk_i(ref_clk_i), .srst_i(srst_i), .uv_reset_i(uv_reset_i),
   .fuse_rd_o(fuse_rd_o), .msg_valid_i(msg_valid_i),
   .msg_crc_ok_i(msg_crc_ok_i), .msg_long_i(msg_long_i),
   .msg_enhanced_i(msg_enhanced_i), .msg_cmd_i(msg_cmd_i),
   .xfer_start_i(xfer_start_i), .startup_flag_o(startup_flag_o),
   .selftest_active_flag_o(selftest_active_flag_o),
   .bus_ready_o(bus_ready_o), .accel_valid_o(accel_valid_o),
   .initialized_o(initialized_o), .cmd_stb_o(cmd_stb_o),
   .resp_req_o(resp_req_o));
`default_nettype wire
